// >>> omc_pkg.sv
// Package of constants and types for the operation mode controller.
package omc_pkg;
    localparam int NUM_CH = 8;
    localparam int NUM_IN = 2;
    localparam logic [7:0] MAP0_RESET = 8'h04;
    localparam logic [7:0] MAP1_RESET = 8'h08;
    localparam logic [7:0] LIMP_CH_MASK = 8'h0C;
    localparam logic [1:0] MODE_CODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_CODE_LIMP = 2'h1;
    localparam logic [1:0] MODE_CODE_ACTIVE = 2'h2;
    localparam logic [1:0] MODE_CODE_IDLE = 2'h3;
    localparam int TRANS_TIME_NS = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TRANS_CYCLES = (TRANS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCNT_W = 8;

    typedef enum logic [1:0] {
        OMC_SLEEP = 2'h0,
        OMC_IDLE = 2'h1,
        OMC_ACTIVE = 2'h3,
        OMC_LIMP = 2'h2
    } omc_mode_t;
endpackage : omc_pkg

// >>> omc_input_map.sv
// Maps the direct inputs onto channels through the two mapping registers.
module omc_input_map
    import omc_pkg::*;
(
    input wire logic [NUM_IN-1:0] direct_input_n_i,
    input wire logic [7:0] map0_i,
    input wire logic [7:0] map1_i,
    output logic [NUM_CH-1:0] mapped_o
);
    always_comb begin
        mapped_o = (direct_input_n_i[0] ? map0_i : 8'h00) | (direct_input_n_i[1] ? map1_i : 8'h00);
    end
endmodule // omc_input_map

// >>> omc_sticky_flag.sv
// Sticky flag where a set wins over a simultaneous clear.
module omc_sticky_flag (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule // omc_sticky_flag

// >>> omc_mode_ctrl.sv
// Operation mode controller with register gating, resets and supply flags.
// How it works
// (R1) Power-on when supply high and pin active.
// (R2) Sleep: channels off, registers at reset.
// (R3) Idle: channels off, no diagnosis, SPI works.
// (R4) Idle keeps the channel fault latches.
// (R5) Wake high plus input or bit: Active.
// (R6) Keep-active clear: idle when nothing requested.
// (R7) Keep-active set: stay Active.
// (R8) Logic undervoltage, inputs low: go Idle.
// (R9) Input high enters Active despite zero maps.
// (R10) Wake low, input high: Limp Home.
// (R11) Limp Home: reads allowed, writes ignored.
// (R12) Limp Home forces supply flags, mode 01.
// (R13) Limp Home: first command sets transmission error.
// (R14) Limp Home holds open-load flags at zero.
// (R15) Limp Home: other registers at default.
// (R16) Limp Home: only channels 2 and 3.
// (R17) Controller avoids SPI during Active/Limp change; not enforced here, spi_available_o stays high through it.
// (R18) Turn-on outside Active/Limp waits transition time.
// (R19) Register reset: logic supply low, wake low, soft.
// (R20) Soft reset keeps faults, clears supply flags.
// (R21) Register reset restores map defaults, channels off.
// (R22) Load undervoltage while operative sets flag.
// (R23) Flag clears after diagnosis readout when recovered.
// (R24) Switch-on request picks Active or Limp by wake.
// (R25) Wake low and inputs low: Sleep.
module omc_mode_ctrl
    import omc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wake_i,
    input wire logic [NUM_IN-1:0] direct_input_n_i,
    input wire logic load_supply_present_i,
    input wire logic load_supply_above_min_operative_i,
    input wire logic load_supply_below_undervoltage_i,
    input wire logic logic_supply_present_i,
    input wire logic logic_supply_above_undervoltage_i,
    input wire logic logic_supply_above_low_power_i,
    input wire logic spi_cmd_i,
    input wire logic spi_write_i,
    input wire logic [NUM_CH-1:0] wr_channel_on_bits_i,
    input wire logic wr_keep_active_bit_i,
    input wire logic wr_soft_reset_bit_i,
    input wire logic [7:0] wr_input0_channel_map_i,
    input wire logic [7:0] wr_input1_channel_map_i,
    input wire logic [1:0] wr_sel_i,
    input wire logic diag_readout_i,
    input wire logic [NUM_CH-1:0] channel_fault_event_i,
    input wire logic [NUM_CH-1:0] channel_fault_clear_i,
    input wire logic [NUM_CH-1:0] output_status_monitor_i,
    input wire logic open_load_on_event_i,
    input wire logic open_load_off_event_i,
    output logic power_on_o,
    output logic [1:0] mode_o,
    output logic [NUM_CH-1:0] channel_drive_o,
    output logic diag_enable_o,
    output logic spi_available_o,
    output logic [NUM_CH-1:0] channel_on_bits_o,
    output logic keep_active_bit_o,
    output logic [7:0] input0_channel_map_o,
    output logic [7:0] input1_channel_map_o,
    output logic [NUM_CH-1:0] channel_fault_latch_o,
    output logic [NUM_CH-1:0] output_status_monitor_bits_o,
    output logic load_supply_undervoltage_flag_o,
    output logic logic_supply_low_flag_o,
    output logic transmission_error_flag_o,
    output logic open_load_on_state_flag_o,
    output logic open_load_off_state_flag_o
);
    typedef struct packed {
        omc_mode_t mode;
        logic power_on;
        logic [NUM_CH-1:0] on_bits;
        logic keep_active;
        logic [7:0] map0;
        logic [7:0] map1;
        logic [NUM_CH-1:0] fault;
        logic [NUM_CH-1:0] osm;
        logic uv_flag;
        logic lop_flag;
        logic transmission_error_flag;
        logic ol_on;
        logic ol_off;
        logic [TCNT_W-1:0] tcnt;
        logic [NUM_CH-1:0] drive;
    } omc_state_t;

    omc_state_t s_q;
    omc_state_t s_d;
    logic [NUM_CH-1:0] mapped;
    logic any_in;
    logic reg_reset;
    logic soft_rst;
    logic wr_ok;
    logic [NUM_CH-1:0] want;
    logic limp_cmd_seen;

    omc_input_map u_map (
        .direct_input_n_i(direct_input_n_i),
        .map0_i(s_q.map0),
        .map1_i(s_q.map1),
        .mapped_o(mapped)
    );

    assign any_in = |direct_input_n_i;

    function automatic logic write_sel(input logic [1:0] sel, input logic [1:0] v);
        return sel == v;
    endfunction

    // True in the modes that refuse register writes and hold register defaults.
    function automatic logic regs_locked(input omc_mode_t m);
        return m == OMC_LIMP || m == OMC_SLEEP;
    endfunction

    // True once the mode transition time has fully elapsed.
    function automatic logic trans_done(input logic [TCNT_W-1:0] cnt);
        return cnt == TCNT_W'(TRANS_CYCLES);
    endfunction

    // True in the modes in which channels may be driven.
    function automatic logic drive_mode(input omc_mode_t m);
        return m == OMC_ACTIVE || m == OMC_LIMP;
    endfunction

    always_comb begin
        s_d = s_q;
        wr_ok = spi_write_i && !regs_locked(s_q.mode)
            && logic_supply_above_undervoltage_i; // [R11] [R3]
        soft_rst = wr_ok && write_sel(wr_sel_i, 2'h1) && wr_soft_reset_bit_i; // [R19]
        reg_reset = !logic_supply_present_i || !logic_supply_above_undervoltage_i
            || !wake_i || soft_rst; // [R19]
        // Power-on indication.
        s_d.power_on = (load_supply_present_i || logic_supply_present_i)
            && (any_in || wake_i)
            && (load_supply_above_min_operative_i || logic_supply_above_low_power_i); // [R1]
        // Register writes.
        if (wr_ok) begin
            case (wr_sel_i)
                2'h0: s_d.on_bits = wr_channel_on_bits_i;
                2'h1: s_d.keep_active = wr_keep_active_bit_i;
                2'h2: s_d.map0 = wr_input0_channel_map_i;
                2'h3: s_d.map1 = wr_input1_channel_map_i;
                default: s_d.on_bits = s_q.on_bits;
            endcase
        end
        if (reg_reset || regs_locked(s_q.mode)) begin
            s_d.on_bits = '0; // [R2] [R15] [R21]
            s_d.keep_active = 1'b0;
            s_d.map0 = MAP0_RESET; // [R21]
            s_d.map1 = MAP1_RESET;
        end
        // Mode selection.
        case (s_q.mode)
            OMC_SLEEP, OMC_IDLE: begin
                if (!wake_i && any_in) begin
                    s_d.mode = OMC_LIMP; // [R10] [R24]
                end else if (wake_i && (any_in || |s_q.on_bits)) begin
                    s_d.mode = OMC_ACTIVE; // [R5] [R9] [R24]
                end else if (!wake_i) begin
                    s_d.mode = OMC_SLEEP; // [R25]
                end else begin
                    s_d.mode = OMC_IDLE;
                end
            end
            OMC_ACTIVE: begin
                if (!wake_i) begin
                    s_d.mode = any_in ? OMC_LIMP : OMC_SLEEP; // [R10] [R25]
                end else if (!logic_supply_above_undervoltage_i && !any_in) begin
                    s_d.mode = OMC_IDLE; // [R8]
                end else if (!s_q.keep_active && !any_in && !(|s_q.on_bits)) begin
                    s_d.mode = OMC_IDLE; // [R6]
                end else begin
                    s_d.mode = OMC_ACTIVE; // [R7]
                end
            end
            OMC_LIMP: begin
                if (wake_i) begin
                    s_d.mode = OMC_ACTIVE;
                end else if (!any_in) begin
                    s_d.mode = OMC_SLEEP; // [R25]
                end else begin
                    s_d.mode = OMC_LIMP;
                end
            end
            default: s_d.mode = OMC_SLEEP;
        endcase
        // Transition delay before channels may turn on.
        if (drive_mode(s_q.mode)) begin
            if (!trans_done(s_q.tcnt)) begin
                s_d.tcnt = s_q.tcnt + 1'b1; // [R18]
            end
        end else begin
            s_d.tcnt = '0;
        end
        // Channel drive.
        want = '0;
        if (s_d.mode == OMC_ACTIVE) begin
            want = s_q.on_bits | mapped;
        end else if (s_d.mode == OMC_LIMP) begin
            want = mapped & LIMP_CH_MASK; // [R10] [R16]
        end
        if (!trans_done(s_q.tcnt) || !load_supply_present_i) begin
            want = '0; // [R2] [R3] [R18]
        end
        s_d.drive = want;
        // Fault latches survive Idle and soft reset.
        s_d.fault = channel_fault_event_i | (s_q.fault & ~channel_fault_clear_i); // [R4] [R20]
        if (s_q.mode == OMC_SLEEP) begin
            s_d.fault = '0; // [R2]
        end
        s_d.osm = output_status_monitor_i; // [R15]
        // Load supply undervoltage flag.
        if (s_q.power_on && load_supply_below_undervoltage_i) begin
            s_d.uv_flag = 1'b1; // [R22]
        end else if (soft_rst) begin
            s_d.uv_flag = 1'b0; // [R20]
        end else if (diag_readout_i && load_supply_above_min_operative_i) begin
            s_d.uv_flag = 1'b0; // [R23]
        end
        if (!logic_supply_above_low_power_i && logic_supply_present_i) begin
            s_d.lop_flag = 1'b1;
        end else if (soft_rst || diag_readout_i) begin
            s_d.lop_flag = 1'b0; // [R20]
        end
        // Open-load flags, diagnosis only in Active mode.
        if (s_q.mode == OMC_ACTIVE) begin
            s_d.ol_on = open_load_on_event_i | (s_q.ol_on & ~diag_readout_i);
            s_d.ol_off = open_load_off_event_i | (s_q.ol_off & ~diag_readout_i);
        end else if (s_q.mode == OMC_LIMP) begin
            s_d.ol_on = 1'b0; // [R14]
            s_d.ol_off = 1'b0; // [R14]
        end
        // Transmission error flag.
        if (s_q.mode != OMC_LIMP) begin
            s_d.transmission_error_flag = (s_q.transmission_error_flag & ~spi_cmd_i);
        end else if (spi_cmd_i) begin
            s_d.transmission_error_flag = !limp_cmd_seen; // [R13]
        end
        // Sleep clears the supply flags; other resets leave them to their own logic.
        if (s_q.mode == OMC_SLEEP) begin
            s_d.uv_flag = 1'b0; // [R2]
            s_d.lop_flag = 1'b0; // [R2]
        end
        if (s_q.mode == OMC_SLEEP || reg_reset) begin
            if (s_q.mode != OMC_LIMP) begin
                s_d.transmission_error_flag = 1'b0; // [R13]
            end
            s_d.ol_on = 1'b0;
            s_d.ol_off = 1'b0;
        end
        if (s_q.mode == OMC_LIMP) begin
            s_d.uv_flag = 1'b1; // [R12]
            s_d.lop_flag = 1'b1; // [R12]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '{mode: OMC_SLEEP, map0: MAP0_RESET, map1: MAP1_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    omc_sticky_flag u_cmd_seen (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i(spi_cmd_i && s_q.mode == OMC_LIMP), // [R13]
        .clear_i(s_q.mode != OMC_LIMP),
        .flag_o(limp_cmd_seen)
    );

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_o <= MODE_CODE_SLEEP;
            diag_enable_o <= 1'b0;
            spi_available_o <= 1'b0;
        end else begin
            case (s_d.mode)
                OMC_LIMP: mode_o <= MODE_CODE_LIMP; // [R12]
                OMC_ACTIVE: mode_o <= MODE_CODE_ACTIVE;
                OMC_IDLE: mode_o <= MODE_CODE_IDLE;
                default: mode_o <= MODE_CODE_SLEEP;
            endcase
            diag_enable_o <= s_d.mode == OMC_ACTIVE; // [R3]
            spi_available_o <= s_d.mode != OMC_SLEEP && logic_supply_above_undervoltage_i;
        end
    end

    assign power_on_o = s_q.power_on;
    assign channel_drive_o = s_q.drive;
    assign channel_on_bits_o = s_q.on_bits;
    assign keep_active_bit_o = s_q.keep_active;
    assign input0_channel_map_o = s_q.map0;
    assign input1_channel_map_o = s_q.map1;
    assign channel_fault_latch_o = s_q.fault;
    assign output_status_monitor_bits_o = s_q.osm;
    assign load_supply_undervoltage_flag_o = s_q.uv_flag;
    assign logic_supply_low_flag_o = s_q.lop_flag;
    assign transmission_error_flag_o = s_q.transmission_error_flag;
    assign open_load_on_state_flag_o = s_q.ol_on;
    assign open_load_off_state_flag_o = s_q.ol_off;
endmodule // omc_mode_ctrl

// >>> omc_mode_ctrl_assertions.sv
// Concurrent checks on the ports of the operation mode controller.
module omc_mode_ctrl_assertions
    import omc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wake_i,
    input wire logic [NUM_IN-1:0] direct_input_n_i,
    input wire logic logic_supply_above_undervoltage_i,
    input wire logic spi_write_i,
    input wire logic [NUM_CH-1:0] channel_fault_clear_i,
    input wire logic [1:0] mode_o,
    input wire logic [NUM_CH-1:0] channel_drive_o,
    input wire logic diag_enable_o,
    input wire logic [NUM_CH-1:0] channel_on_bits_o,
    input wire logic [NUM_CH-1:0] channel_fault_latch_o,
    input wire logic load_supply_undervoltage_flag_o,
    input wire logic logic_supply_low_flag_o,
    input wire logic open_load_on_state_flag_o,
    input wire logic open_load_off_state_flag_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_sleep_drive_off: assert property (
        mode_o == MODE_CODE_SLEEP && $past(mode_o) == MODE_CODE_SLEEP |-> channel_drive_o == '0)
        else $error("Channels driven in sleep.");
    chk_idle_quiet: assert property (
        mode_o == MODE_CODE_IDLE && $past(mode_o) == MODE_CODE_IDLE
        |-> channel_drive_o == '0 && !diag_enable_o) else $error("Idle not quiet.");
    chk_idle_keeps_faults: assert property (
        (mode_o == MODE_CODE_IDLE && channel_fault_clear_i == '0 && wake_i
        && logic_supply_above_undervoltage_i) ##1 mode_o == MODE_CODE_IDLE
        |-> (channel_fault_latch_o & $past(channel_fault_latch_o)) == $past(channel_fault_latch_o))
        else $error("Fault latch lost in idle.");
    chk_active_entry: assert property (
        wake_i && |direct_input_n_i && logic_supply_above_undervoltage_i
        |-> ##[1:2] mode_o == MODE_CODE_ACTIVE) else $error("Active not entered.");
    chk_limp_entry: assert property (
        !wake_i && |direct_input_n_i && logic_supply_above_undervoltage_i
        |-> ##[1:2] mode_o == MODE_CODE_LIMP) else $error("Limp home not entered.");
    chk_limp_no_write: assert property (
        mode_o == MODE_CODE_LIMP && $past(mode_o) == MODE_CODE_LIMP && spi_write_i
        |=> channel_on_bits_o == '0) else $error("Write accepted in limp home.");
    chk_limp_flags: assert property (
        mode_o == MODE_CODE_LIMP && $past(mode_o) == MODE_CODE_LIMP
        |-> load_supply_undervoltage_flag_o && logic_supply_low_flag_o
        && !open_load_on_state_flag_o && !open_load_off_state_flag_o)
        else $error("Limp home flags wrong.");
    chk_limp_channels: assert property (
        mode_o == MODE_CODE_LIMP |-> (channel_drive_o & ~LIMP_CH_MASK) == '0)
        else $error("Forbidden channel on in limp home.");
    chk_turn_on_delay: assert property (
        mode_o == MODE_CODE_IDLE ##1 mode_o == MODE_CODE_ACTIVE |-> channel_drive_o == '0 [*8])
        else $error("Channel on before transition time.");
    chk_sleep_entry: assert property (
        !wake_i && direct_input_n_i == '0 |=> mode_o == MODE_CODE_SLEEP)
        else $error("Sleep not entered.");
endmodule // omc_mode_ctrl_assertions

bind omc_mode_ctrl omc_mode_ctrl_assertions chk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wake_i(wake_i),
    .direct_input_n_i(direct_input_n_i),
    .logic_supply_above_undervoltage_i(logic_supply_above_undervoltage_i),
    .spi_write_i(spi_write_i),
    .channel_fault_clear_i(channel_fault_clear_i),
    .mode_o(mode_o),
    .channel_drive_o(channel_drive_o),
    .diag_enable_o(diag_enable_o),
    .channel_on_bits_o(channel_on_bits_o),
    .channel_fault_latch_o(channel_fault_latch_o),
    .load_supply_undervoltage_flag_o(load_supply_undervoltage_flag_o),
    .logic_supply_low_flag_o(logic_supply_low_flag_o),
    .open_load_on_state_flag_o(open_load_on_state_flag_o),
    .open_load_off_state_flag_o(open_load_off_state_flag_o)
);

// >>> omc_mcu_model.sv
// Microcontroller model that drives the pins and the command strobes.
module omc_mcu_model
    import omc_pkg::*;
(
    input wire logic clock_i,
    output logic wake_i,
    output logic [NUM_IN-1:0] direct_input_n_i,
    output logic spi_cmd_i,
    output logic spi_write_i,
    output logic [1:0] wr_sel_i,
    output logic [NUM_CH-1:0] wr_channel_on_bits_i,
    output logic wr_keep_active_bit_i,
    output logic wr_soft_reset_bit_i,
    output logic [7:0] wr_input0_channel_map_i,
    output logic [7:0] wr_input1_channel_map_i,
    output logic diag_readout_i
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic put(input logic [7:0] d);
        wr_channel_on_bits_i = d;
        wr_keep_active_bit_i = d[0];
        wr_soft_reset_bit_i = d[1];
        wr_input0_channel_map_i = d;
        wr_input1_channel_map_i = d;
    endtask
    initial begin
        {wake_i, direct_input_n_i, spi_cmd_i, spi_write_i, diag_readout_i, wr_sel_i} = '0;
        put(8'h00);
    end
    // Pin changes are applied at the next falling clock edge.
    task automatic pins(input logic w, input logic [1:0] d);
        @(negedge clock_i);
        wake_i = w;
        direct_input_n_i = d;
    endtask
    // A write is one command pulse; the data lines are inverted once it is taken.
    task automatic write(input logic [1:0] s, input logic [7:0] d);
        @(negedge clock_i);
        wr_sel_i = s;
        put(d);
        {spi_write_i, spi_cmd_i} = 2'h3;
        @(negedge clock_i);
        {spi_write_i, spi_cmd_i} = 2'h0;
        put(~d);
    endtask
    task automatic readout;
        @(negedge clock_i);
        diag_readout_i = 1'b1;
        @(negedge clock_i);
        diag_readout_i = 1'b0;
    endtask
endmodule // omc_mcu_model

// >>> tb_omc_mode_ctrl.sv
// Testbench of the operation mode controller.
module tb_omc_mode_ctrl;
    import omc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, rst_n_i, wake_i, spi_cmd_i, spi_write_i, diag_readout_i, power_on_o;
    logic wr_keep_active_bit_i, wr_soft_reset_bit_i, diag_enable_o, spi_available_o;
    logic load_supply_present_i, load_supply_above_min_operative_i;
    logic load_supply_below_undervoltage_i, logic_supply_present_i;
    logic logic_supply_above_undervoltage_i, logic_supply_above_low_power_i;
    logic open_load_on_event_i, open_load_off_event_i, keep_active_bit_o;
    logic load_supply_undervoltage_flag_o, logic_supply_low_flag_o, transmission_error_flag_o;
    logic open_load_on_state_flag_o, open_load_off_state_flag_o;
    logic [1:0] wr_sel_i, mode_o;
    logic [NUM_IN-1:0] direct_input_n_i;
    logic [7:0] wr_input0_channel_map_i, wr_input1_channel_map_i;
    logic [7:0] input0_channel_map_o, input1_channel_map_o;
    logic [NUM_CH-1:0] wr_channel_on_bits_i, channel_fault_event_i, channel_fault_clear_i;
    logic [NUM_CH-1:0] output_status_monitor_i, channel_drive_o, channel_on_bits_o;
    logic [NUM_CH-1:0] channel_fault_latch_o, output_status_monitor_bits_o;
    int n_fail, checks, cyc;
    omc_mode_ctrl uut (.*);
    omc_mcu_model mcu (.*);
    always #2.5 clock_i = ~clock_i;
    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        {load_supply_present_i, load_supply_above_min_operative_i} = 2'h3;
        {logic_supply_present_i, logic_supply_above_undervoltage_i} = 2'h3;
        logic_supply_above_low_power_i = 1'b1;
        {load_supply_below_undervoltage_i, open_load_on_event_i, open_load_off_event_i} = 3'h0;
        {channel_fault_event_i, channel_fault_clear_i} = '0;
        output_status_monitor_i = 8'hA5;
        step(5);
        rst_n_i = 1'b1;
        check(mode_o, MODE_CODE_SLEEP);
        check(input0_channel_map_o, MAP0_RESET);
        mcu.pins(1'b1, 2'h0);
        step(3);
        check(power_on_o, 1'b1);
        check(mode_o, MODE_CODE_IDLE);
        check(diag_enable_o, 1'b0);
        check(spi_available_o, 1'b1);
        $display("test power_up done");
        mcu.write(2'h0, 8'h11);
        step(5);
        check(mode_o, MODE_CODE_ACTIVE);
        check(channel_drive_o, 8'h00);
        check(diag_enable_o, 1'b1);
        step(25);
        check(channel_drive_o, 8'h11);
        mcu.write(2'h1, 8'h01);
        check(keep_active_bit_o, 1'b1);
        mcu.write(2'h0, 8'h00);
        step(3);
        check(mode_o, MODE_CODE_ACTIVE);
        check(channel_on_bits_o, 8'h00);
        channel_fault_event_i = 8'h40;
        step(1);
        channel_fault_event_i = '0;
        mcu.write(2'h1, 8'h00);
        step(5);
        check(mode_o, MODE_CODE_IDLE);
        check(channel_fault_latch_o, 8'h40);
        $display("test active_idle done");
        mcu.write(2'h2, 8'h00);
        mcu.write(2'h3, 8'h00);
        mcu.pins(1'b1, 2'h1);
        step(3);
        check(mode_o, MODE_CODE_ACTIVE);
        step(25);
        check(channel_drive_o, 8'h00);
        mcu.pins(1'b1, 2'h0);
        {load_supply_below_undervoltage_i, load_supply_above_min_operative_i} = 2'h2;
        step(3);
        check(load_supply_undervoltage_flag_o, 1'b1);
        {load_supply_below_undervoltage_i, load_supply_above_min_operative_i} = 2'h1;
        mcu.readout();
        step(2);
        check(load_supply_undervoltage_flag_o, 1'b0);
        load_supply_below_undervoltage_i = 1'b1;
        step(2);
        load_supply_below_undervoltage_i = 1'b0;
        mcu.write(2'h1, 8'h02);
        step(3);
        check(load_supply_undervoltage_flag_o, 1'b0);
        check(channel_fault_latch_o, 8'h40);
        check(input1_channel_map_o, MAP1_RESET);
        $display("test flags_reset done");
        mcu.write(2'h0, 8'h01);
        step(2);
        logic_supply_above_undervoltage_i = 1'b0;
        step(3);
        check(mode_o, MODE_CODE_IDLE);
        check(channel_on_bits_o, 8'h00);
        logic_supply_above_undervoltage_i = 1'b1;
        mcu.pins(1'b0, 2'h1);
        step(3);
        check(mode_o, MODE_CODE_LIMP);
        check({load_supply_undervoltage_flag_o, logic_supply_low_flag_o}, 2'h3);
        {open_load_on_event_i, open_load_off_event_i} = 2'h3;
        mcu.write(2'h0, 8'hFF);
        {open_load_on_event_i, open_load_off_event_i} = 2'h0;
        step(2);
        check({open_load_on_state_flag_o, open_load_off_state_flag_o}, 2'h0);
        check(channel_on_bits_o, 8'h00);
        check(transmission_error_flag_o, 1'b1);
        check(output_status_monitor_bits_o, 8'hA5);
        step(25);
        check(channel_drive_o, MAP0_RESET);
        mcu.pins(1'b0, 2'h3);
        step(25);
        check(channel_drive_o, MAP0_RESET | MAP1_RESET);
        mcu.pins(1'b0, 2'h0);
        step(3);
        check(mode_o, MODE_CODE_SLEEP);
        check(channel_drive_o, 8'h00);
        check(spi_available_o, 1'b0);
        $display("test limp_sleep done");
        end_of_test();
    end
endmodule // tb_omc_mode_ctrl
